// file: hdl/stop_cmd_top.sv
// Stop mode selection and filtered position command input
// Functional notes
// - Group-one alarm: 0 brake, 1 brake then release, 2 coast; default 2
// - Group-two alarm: 0 zero-speed stop (default), 1 same as group one
// - Overtravel: 0 as group one, 1/2 torque-limited stop then lock/free
// - Zero-speed stop only in position or speed control modes
// - Position target is the command count; speed follows command rate
// - Source: 0 low-speed, 1 high-speed, 3 internal, 2 reserved
// - Pulses narrower than the filter width are dropped as noise
// - Filter codes 0-7 presets (default 2), 8 custom 12.5 ns steps
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module stop_cmd_top #(
    parameter int RATE_WINDOW = stop_cmd_pkg::RATE_WINDOW_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        low_pulse_pin,
    input  wire logic        low_dir_pin,
    input  wire logic        high_pulse_pin,
    input  wire logic        high_dir_pin,
    input  wire logic        int_step,
    input  wire logic        int_dir,
    input  wire logic [1:0]  control_mode,
    input  wire logic        alarm_group1,
    input  wire logic        alarm_group2,
    input  wire logic        overtravel,
    input  wire logic        motor_stopped,
    output logic             dynamic_brake,
    output logic             motor_free,
    output logic             zero_speed_stop,
    output logic             torque_decel,
    output logic             servo_lock,
    output logic [9:0]       emergency_stop_torque,
    output logic [31:0]      position_target,
    output logic [31:0]      command_rate
);
    typedef struct packed {
        logic [1:0]                group1_alarm_stop_select;
        logic                      group2_alarm_stop_select;
        logic [1:0]                overtravel_stop_select;
        logic [1:0]                command_source_select;
        logic [3:0]                pulse_filter_select;
        logic [12:0]               custom_filter_width;
        logic [9:0]                torq;
        stop_cmd_pkg::stop_state_t stop;
        logic [31:0]               pos;
        logic                      prev_pulse;
        logic [31:0]               win_cnt;
        logic [31:0]               win_pulses;
        logic [31:0]               rate;
        logic                      aw_got;
        logic [7:0]                aw_addr;
        logic                      w_got;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;

    logic [3:0]                pins;
    logic [3:0]                flt;
    logic [13:0]               flt_width;
    logic                      sel_pulse;
    logic                      sel_dir;
    logic                      step;
    stop_cmd_pkg::stop_state_t g1_act;
    stop_cmd_pkg::stop_state_t entry;
    logic [31:0]               ctrl_word;
    logic [31:0]               stat_word;
    logic [31:0]               wr_word;
    logic [31:0]               filt_word;

    // True for any register offset
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = a == stop_cmd_pkg::OFS_CTRL || a == stop_cmd_pkg::OFS_FILT
               || a == stop_cmd_pkg::OFS_TORQ || a == stop_cmd_pkg::OFS_STAT
               || a == stop_cmd_pkg::OFS_POS  || a == stop_cmd_pkg::OFS_RATE;
    endfunction

    // Byte lanes of a write merged over the old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? d[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    // One filter per command pin
    assign pins = {high_dir_pin, high_pulse_pin, low_dir_pin, low_pulse_pin};
    assign flt_width = stop_cmd_pkg::filter_ticks(s_r.pulse_filter_select,
                                                  s_r.custom_filter_width);
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flt
            pulse_filter u_flt (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .pin_in    (pins[gi]),
                .width     (flt_width),
                .level_out (flt[gi])
            );
        end
    endgenerate

    // Command source multiplexer and step detection
    always_comb begin
        sel_pulse = 1'b0;
        sel_dir = 1'b0;
        step = 1'b0;
        unique case (s_r.command_source_select)
            stop_cmd_pkg::SRC_LOW: begin
                sel_pulse = flt[0];
                sel_dir = flt[1];
                step = flt[0] && !s_r.prev_pulse;
            end
            stop_cmd_pkg::SRC_HIGH: begin
                sel_pulse = flt[2];
                sel_dir = flt[3];
                step = flt[2] && !s_r.prev_pulse;
            end
            stop_cmd_pkg::SRC_INT: begin
                sel_dir = int_dir;
                step = int_step;
            end
            stop_cmd_pkg::SRC_RSVD: begin
                step = 1'b0;
            end
        endcase
    end

    // Stop action demanded by the present alarm and overtravel inputs
    always_comb begin
        g1_act = (s_r.group1_alarm_stop_select == stop_cmd_pkg::G1_COAST)
               ? stop_cmd_pkg::ST_COAST : stop_cmd_pkg::ST_BRAKE;
        if (alarm_group1) begin
            entry = g1_act;
        end else if (alarm_group2) begin
            if (s_r.group2_alarm_stop_select == stop_cmd_pkg::G2_ZERO_SPEED
                && (control_mode == stop_cmd_pkg::MODE_POS
                    || control_mode == stop_cmd_pkg::MODE_SPEED)) begin
                entry = stop_cmd_pkg::ST_ZERO;
            end else begin
                entry = g1_act;
            end
        end else if (overtravel) begin
            entry = (s_r.overtravel_stop_select == stop_cmd_pkg::OT_AS_G1)
                  ? g1_act : stop_cmd_pkg::ST_DECEL;
        end else begin
            entry = stop_cmd_pkg::ST_IDLE;
        end
    end

    // Readback words
    assign ctrl_word = {16'h0000,
                        s_r.pulse_filter_select, 2'h0,
                        s_r.command_source_select, 2'h0,
                        s_r.overtravel_stop_select, 1'h0,
                        s_r.group2_alarm_stop_select,
                        s_r.group1_alarm_stop_select};
    assign stat_word = {20'h00000, flt, s_r.stop};
    assign wr_word = merge(ctrl_word, s_r.w_data, s_r.w_strb);
    // Full custom width word, so that large writes clamp instead of wrapping
    assign filt_word = merge({19'h0, s_r.custom_filter_width},
                             s_r.w_data, s_r.w_strb);

    // Next state of registers, position, stop machine and bus slave
    always_comb begin
        s_nxt = s_r;
        // Stop machine with follow-on steps once the motor has stopped
        s_nxt.stop = entry;
        unique case (s_r.stop)
            stop_cmd_pkg::ST_BRAKE, stop_cmd_pkg::ST_RELEASE: begin
                if (entry == stop_cmd_pkg::ST_BRAKE
                    && s_r.group1_alarm_stop_select
                       == stop_cmd_pkg::G1_DB_RELEASE
                    && (motor_stopped
                        || s_r.stop == stop_cmd_pkg::ST_RELEASE)) begin
                    s_nxt.stop = stop_cmd_pkg::ST_RELEASE;
                end
            end
            stop_cmd_pkg::ST_DECEL, stop_cmd_pkg::ST_LOCK,
            stop_cmd_pkg::ST_FREE: begin
                if (entry == stop_cmd_pkg::ST_DECEL
                    && (motor_stopped
                        || s_r.stop != stop_cmd_pkg::ST_DECEL)) begin
                    s_nxt.stop = (s_r.overtravel_stop_select
                                  == stop_cmd_pkg::OT_DECEL_LOCK)
                               ? stop_cmd_pkg::ST_LOCK
                               : stop_cmd_pkg::ST_FREE;
                end
            end
            stop_cmd_pkg::ST_IDLE, stop_cmd_pkg::ST_COAST,
            stop_cmd_pkg::ST_ZERO: begin
                s_nxt.stop = entry;
            end
            default: begin
                s_nxt.stop = stop_cmd_pkg::ST_IDLE;
            end
        endcase
        // Position count and command rate per window
        s_nxt.prev_pulse = sel_pulse;
        if (step) begin
            s_nxt.pos = sel_dir ? s_r.pos - 32'h1 : s_r.pos + 32'h1;
        end
        if (s_r.win_cnt == 32'(RATE_WINDOW - 1)) begin
            s_nxt.rate = s_r.win_pulses + {31'h0, step};
            s_nxt.win_pulses = '0;
            s_nxt.win_cnt = '0;
        end else begin
            s_nxt.win_pulses = s_r.win_pulses + {31'h0, step};
            s_nxt.win_cnt = s_r.win_cnt + 32'h1;
        end
        // Write channel: address and data in either order
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.w_data = wdata;
            s_nxt.w_strb = wstrb;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = reg_hit(s_r.aw_addr) ? 2'h0 : 2'h2;
            if (s_r.aw_addr == stop_cmd_pkg::OFS_CTRL) begin
                s_nxt.group1_alarm_stop_select =
                    wr_word[stop_cmd_pkg::G1_LSB +: 2];
                s_nxt.group2_alarm_stop_select =
                    wr_word[stop_cmd_pkg::G2_BIT];
                s_nxt.overtravel_stop_select =
                    wr_word[stop_cmd_pkg::OT_LSB +: 2];
                s_nxt.command_source_select =
                    wr_word[stop_cmd_pkg::SRC_LSB +: 2];
                s_nxt.pulse_filter_select =
                    wr_word[stop_cmd_pkg::FSEL_LSB +: 4];
            end else if (s_r.aw_addr == stop_cmd_pkg::OFS_FILT) begin
                s_nxt.custom_filter_width = 13'(filt_word);
                if (filt_word > 32'(stop_cmd_pkg::CUSTOM_MAX)) begin
                    s_nxt.custom_filter_width = stop_cmd_pkg::CUSTOM_MAX;
                end
            end else if (s_r.aw_addr == stop_cmd_pkg::OFS_TORQ) begin
                s_nxt.torq = 10'(merge({22'h0, s_r.torq},
                                       s_r.w_data, s_r.w_strb));
            end
        end
        // Read channel: one read at a time
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = reg_hit(araddr) ? 2'h0 : 2'h2;
            unique case (araddr)
                stop_cmd_pkg::OFS_CTRL: s_nxt.rdata = ctrl_word;
                stop_cmd_pkg::OFS_FILT:
                    s_nxt.rdata = {19'h0, s_r.custom_filter_width};
                stop_cmd_pkg::OFS_TORQ: s_nxt.rdata = {22'h0, s_r.torq};
                stop_cmd_pkg::OFS_STAT: s_nxt.rdata = stat_word;
                stop_cmd_pkg::OFS_POS:  s_nxt.rdata = s_r.pos;
                stop_cmd_pkg::OFS_RATE: s_nxt.rdata = s_r.rate;
                default:                s_nxt.rdata = 32'h0;
            endcase
        end
    end

    // State register with documented defaults after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.group1_alarm_stop_select <= stop_cmd_pkg::G1_RST;
            s_r.group2_alarm_stop_select <= stop_cmd_pkg::G2_RST;
            s_r.overtravel_stop_select <= stop_cmd_pkg::OT_RST;
            s_r.command_source_select <= stop_cmd_pkg::SRC_RST;
            s_r.pulse_filter_select <= stop_cmd_pkg::FSEL_RST;
            s_r.custom_filter_width <= stop_cmd_pkg::CUSTOM_RST;
            s_r.torq <= stop_cmd_pkg::TORQ_RST;
            s_r.stop <= stop_cmd_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign awready = !s_r.aw_got;
    assign wready = !s_r.w_got;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = !s_r.rvalid;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    assign dynamic_brake = s_r.stop == stop_cmd_pkg::ST_BRAKE;
    assign motor_free = s_r.stop == stop_cmd_pkg::ST_COAST
                     || s_r.stop == stop_cmd_pkg::ST_RELEASE
                     || s_r.stop == stop_cmd_pkg::ST_FREE;
    assign zero_speed_stop = s_r.stop == stop_cmd_pkg::ST_ZERO;
    assign torque_decel = s_r.stop == stop_cmd_pkg::ST_DECEL;
    assign servo_lock = s_r.stop == stop_cmd_pkg::ST_LOCK;
    assign emergency_stop_torque = s_r.torq;
    assign position_target = s_r.pos;
    assign command_rate = s_r.rate;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ot_stopped;
        s_r.stop == stop_cmd_pkg::ST_DECEL && motor_stopped && overtravel
        && !alarm_group1 && !alarm_group2
        && s_r.overtravel_stop_select == stop_cmd_pkg::OT_DECEL_LOCK;
    endsequence

    a_g1_brake: assert property (
        alarm_group1 && s_r.group1_alarm_stop_select
            == stop_cmd_pkg::G1_DB_HOLD |=> dynamic_brake && !motor_free)
        else $error("group one alarm did not brake");
    a_g1_coast: assert property (
        alarm_group1 && s_r.group1_alarm_stop_select
            == stop_cmd_pkg::G1_COAST |=> motor_free && !dynamic_brake)
        else $error("group one alarm did not coast");
    a_g2_zero: assert property (
        !alarm_group1 && alarm_group2 && !s_r.group2_alarm_stop_select
        && control_mode == stop_cmd_pkg::MODE_SPEED |=> zero_speed_stop)
        else $error("group two alarm did not stop at zero speed");
    a_ot_lock: assert property (
        s_ot_stopped |=> servo_lock && !torque_decel)
        else $error("overtravel stop did not lock the servo");
    a_zero_mode: assert property (
        zero_speed_stop |->
            $past(control_mode) != stop_cmd_pkg::MODE_TORQUE)
        else $error("zero speed stop used in torque mode");
    a_pos_count: assert property (
        int_step && !int_dir
        && s_r.command_source_select == stop_cmd_pkg::SRC_INT
        |=> position_target == $past(position_target) + 32'h1)
        else $error("internal command did not advance position");
    a_src_rsvd: assert property (
        s_r.command_source_select == stop_cmd_pkg::SRC_RSVD
        |=> $stable(position_target))
        else $error("reserved source moved the position");
endmodule

// file: hdl/stop_cmd_pkg.sv
// Constants, types and helpers for the stop mode and pulse command block
package stop_cmd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FILT = 8'h04;
    localparam logic [7:0] OFS_TORQ = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_POS  = 8'h10;
    localparam logic [7:0] OFS_RATE = 8'h14;
    // Field positions in the control and status words
    localparam int G1_LSB   = 0;
    localparam int G2_BIT   = 2;
    localparam int OT_LSB   = 4;
    localparam int SRC_LSB  = 8;
    localparam int FSEL_LSB = 12;
    localparam int STAT_PIN_LSB = 8;
    // Values after reset and the custom width limit
    localparam logic [1:0]  G1_RST     = 2'h2;
    localparam logic        G2_RST     = 1'h0;
    localparam logic [1:0]  OT_RST     = 2'h0;
    localparam logic [1:0]  SRC_RST    = 2'h0;
    localparam logic [3:0]  FSEL_RST   = 4'h2;
    localparam logic [12:0] CUSTOM_RST = 13'h0190;
    localparam logic [12:0] CUSTOM_MAX = 13'h1388;
    localparam logic [9:0]  TORQ_RST   = 10'h320;
    // Stop selections
    localparam logic [1:0] G1_DB_HOLD    = 2'h0;
    localparam logic [1:0] G1_DB_RELEASE = 2'h1;
    localparam logic [1:0] G1_COAST      = 2'h2;
    localparam logic       G2_ZERO_SPEED = 1'h0;
    localparam logic [1:0] OT_AS_G1      = 2'h0;
    localparam logic [1:0] OT_DECEL_LOCK = 2'h1;
    // Command sources, filter code of the custom width, control modes
    localparam logic [1:0] SRC_LOW     = 2'h0;
    localparam logic [1:0] SRC_HIGH    = 2'h1;
    localparam logic [1:0] SRC_RSVD    = 2'h2;
    localparam logic [1:0] SRC_INT     = 2'h3;
    localparam logic [3:0] FSEL_CUSTOM = 4'h8;
    localparam logic [1:0] MODE_POS    = 2'h0;
    localparam logic [1:0] MODE_SPEED  = 2'h1;
    localparam logic [1:0] MODE_TORQUE = 2'h2;
    // Timing
    localparam int CLK_PERIOD_PS  = 10000;
    localparam int CUSTOM_STEP_PS = 12500;
    localparam int PRESET_NS [0:7] = '{50, 100, 150, 200, 400, 800, 1600,
                                       3200};
    localparam int RATE_WINDOW_NS  = 1000000;
    localparam int RATE_WINDOW_CYC = RATE_WINDOW_NS / (CLK_PERIOD_PS / 1000);
    // One-hot stop states
    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_BRAKE   = 8'h02,
        ST_RELEASE = 8'h04,
        ST_COAST   = 8'h08,
        ST_ZERO    = 8'h10,
        ST_DECEL   = 8'h20,
        ST_LOCK    = 8'h40,
        ST_FREE    = 8'h80
    } stop_state_t;

    // Filter width in clock ticks, rounded up
    function automatic logic [13:0] filter_ticks(input logic [3:0]  sel,
                                                 input logic [12:0] custom);
        int ps;
        ps = 0;
        if (sel >= FSEL_CUSTOM) begin
            ps = int'(custom) * CUSTOM_STEP_PS;
        end else begin
            ps = PRESET_NS[sel[2:0]] * 1000;
        end
        filter_ticks = 14'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    endfunction
endpackage

// file: hdl/pulse_filter.sv
// Synchroniser and width filter for one command pulse pin
`timescale 1ns/1ns
module pulse_filter (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        pin_in,
    input  wire logic [13:0] width,
    output logic             level_out
);
    typedef struct packed {
        logic [2:0]  sync;
        logic [13:0] cnt;
        logic        level;
    } flt_state_t;

    flt_state_t s_r;
    flt_state_t s_nxt;

    // Accept a new level only once it has stood longer than the width
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync = {s_r.sync[1:0], pin_in};
        if (s_r.sync[1] != s_r.sync[2] || s_r.sync[2] == s_r.level) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= width) begin
            s_nxt.level = s_r.sync[2];
            s_nxt.cnt = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + 14'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level_out = s_r.level;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_filter_reject: assert property (
        $changed(level_out) |-> $past(s_r.cnt) >= $past(width))
        else $error("filtered level changed before the width elapsed");
    a_filter_agree: assert property (
        $changed(level_out) |->
            $past(s_r.sync[2]) == level_out &&
            $past(s_r.sync[1]) == $past(s_r.sync[2]))
        else $error("filtered level taken from an unstable input");
endmodule

// file: tb/pulse_host.sv
// Host controller model sending one command pulse per start request
`timescale 1ns/1ns
module pulse_host (
    input  wire logic        aclk,
    input  wire logic        start,
    input  wire logic [15:0] hi_cyc,
    input  wire logic        down,
    output logic             pulse_pin,
    output logic             dir_pin
);
    logic [15:0] cnt_r = 16'h0000;
    initial pulse_pin = 1'b0;
    initial dir_pin = 1'b0;
    // Direction leads the pulse by one cycle and holds until the next start
    always @(posedge aclk) begin
        if (start) begin
            dir_pin <= down;
            cnt_r   <= hi_cyc;
        end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
        end
        pulse_pin <= (cnt_r != 16'h0000);
    end
endmodule

// file: tb/stop_cmd_top_tb_top.sv
// Self-checking bench for the stop mode and pulse command block
`timescale 1ns/1ns
module stop_cmd_top_tb_top;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, int_step, int_dir;
    logic        low_pulse_pin, low_dir_pin, high_pulse_pin, high_dir_pin;
    logic        alarm_group1, alarm_group2, overtravel, motor_stopped;
    logic        sl, sh, hdn;
    logic [1:0]  bresp, rresp, control_mode;
    logic [7:0]  awaddr, araddr;
    logic [9:0]  emergency_stop_torque;
    logic [4:0]  stop_outs;
    logic [15:0] hcyc;
    logic [31:0] wdata, rdata, position_target, command_rate;
    int          failures, n_checks;
    // Control word, inputs {a1,a2,ot,stopped,mode}, expected one-hot state
    localparam logic [31:0] TAB [12] = '{32'h00002002, 32'h00012404,
        32'h00022008, 32'h00021010, 32'h00021110, 32'h00021208, 32'h00041002,
        32'h00000802, 32'h00100C40, 32'h00200C80, 32'h00100820, 32'h00122808};

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    stop_cmd_top #(.RATE_WINDOW(16)) i_dut (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .low_pulse_pin, .low_dir_pin, .high_pulse_pin,
        .high_dir_pin, .int_step, .int_dir, .control_mode, .alarm_group1,
        .alarm_group2, .overtravel, .motor_stopped,
        .dynamic_brake(stop_outs[4]), .motor_free(stop_outs[3]),
        .zero_speed_stop(stop_outs[2]), .torque_decel(stop_outs[1]),
        .servo_lock(stop_outs[0]),
        .emergency_stop_torque, .position_target, .command_rate);
    pulse_host i_hl (.aclk, .start(sl), .hi_cyc(hcyc), .down(hdn),
        .pulse_pin(low_pulse_pin), .dir_pin(low_dir_pin));
    pulse_host i_hh (.aclk, .start(sh), .hi_cyc(hcyc), .down(hdn),
        .pulse_pin(high_pulse_pin), .dir_pin(high_dir_pin));

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tmo();
        chk("handshake", 34'h1, 34'h0);
        finish_test();
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n <= 100; n++) begin
            if (n == 100) tmo();
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    // Read one word and compare {rresp, rdata}
    task automatic rchk(input logic [7:0] a, input logic [33:0] e);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n <= 100; n++) begin
            if (n == 100) tmo();
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        chk("read", e, {rresp, rdata});
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic t_reset();
        rchk(stop_cmd_pkg::OFS_CTRL, 34'h2002);
        rchk(stop_cmd_pkg::OFS_FILT, 34'h190);
        rchk(8'h40, 34'h200000000);
        chk("torque", 34'h320, 34'(emergency_stop_torque));
        wr(stop_cmd_pkg::OFS_TORQ, 32'h000001F4);
        wr(stop_cmd_pkg::OFS_FILT, 32'h00001FFF);
        rchk(stop_cmd_pkg::OFS_FILT, 34'h1388);
        chk("torque", 34'h1F4, 34'(emergency_stop_torque));
        $display("test reset done");
    endtask

    task automatic t_stop();
        logic [7:0] st;
        logic [4:0] ex;
        foreach (TAB[i]) begin
            st = TAB[i][7:0];
            ex = {st[1], st[2] | st[3] | st[7], st[4], st[5], st[6]};
            wr(stop_cmd_pkg::OFS_CTRL, {16'h0000, TAB[i][31:16]});
            {alarm_group1, alarm_group2, overtravel} <= TAB[i][13:11];
            motor_stopped <= TAB[i][10];
            control_mode  <= TAB[i][9:8];
            repeat (4) @(posedge aclk);
            rchk(stop_cmd_pkg::OFS_STAT, {26'h0, st});
            chk("stop outputs", 34'(ex), 34'(stop_outs));
            {alarm_group1, alarm_group2, overtravel, motor_stopped} <= 4'h0;
            control_mode <= 2'h0;
            repeat (2) @(posedge aclk);
            rchk(stop_cmd_pkg::OFS_STAT, 34'h01);
            chk("stop outputs", 34'h0, 34'(stop_outs));
        end
        $display("test stop done");
    endtask

    task automatic pulse(input logic h, input logic [15:0] w, input logic dn);
        hcyc <= w;
        hdn  <= dn;
        sl   <= !h;
        sh   <= h;
        @(posedge aclk);
        sl <= 1'b0;
        sh <= 1'b0;
        repeat (120) @(posedge aclk);
    endtask

    task automatic t_pulse();
        wr(stop_cmd_pkg::OFS_CTRL, 32'h00000000);
        pulse(1'b0, 16'd20, 1'b0);
        chk("pos", 34'h1, 34'(position_target));
        pulse(1'b0, 16'd3, 1'b0);
        pulse(1'b1, 16'd20, 1'b0);
        chk("pos", 34'h1, 34'(position_target));
        wr(stop_cmd_pkg::OFS_CTRL, 32'h00000100);
        pulse(1'b1, 16'd20, 1'b1);
        chk("pos", 34'h0, 34'(position_target));
        wr(stop_cmd_pkg::OFS_CTRL, 32'h00000200);
        pulse(1'b0, 16'd20, 1'b0);
        pulse(1'b1, 16'd20, 1'b0);
        chk("pos", 34'h0, 34'(position_target));
        wr(stop_cmd_pkg::OFS_FILT, 32'h00000010);
        wr(stop_cmd_pkg::OFS_CTRL, 32'h00008000);
        pulse(1'b0, 16'd16, 1'b0);
        pulse(1'b0, 16'd80, 1'b0);
        chk("pos", 34'h1, 34'(position_target));
        $display("test pulse done");
    endtask

    task automatic t_int();
        wr(stop_cmd_pkg::OFS_CTRL, 32'h00000300);
        for (int i = 0; i < 32; i++) begin
            int_dir  <= (i == 31);
            int_step <= 1'b1;
            @(posedge aclk);
            int_step <= 1'b0;
            @(posedge aclk);
        end
        chk("rate", 34'h8, 34'(command_rate));
        rchk(stop_cmd_pkg::OFS_POS, 34'h1F);
        repeat (40) @(posedge aclk);
        chk("rate", 34'h0, 34'(command_rate));
        $display("test internal done");
    endtask

    initial begin
        failures = 0;
        n_checks = 0;
        aresetn  = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, int_step, int_dir} = '0;
        {alarm_group1, alarm_group2, overtravel, motor_stopped} = '0;
        {sl, sh, hdn, awaddr, araddr, wdata, control_mode, hcyc} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_stop();
        t_pulse();
        t_int();
        finish_test();
    end
endmodule
